// ### pap_datapath.sv
// Per-phase total and fundamental active power datapath with gain.
`timescale 1ns/1ps
`default_nettype none

module pap_datapath #(
  parameter int NUM_PHASES = pap_pkg::NUM_PHASES,
  parameter int LPF_SHIFT = pap_pkg::LPF_SHIFT,
  parameter int FUND_LPF_SHIFT = pap_pkg::FUND_LPF_SHIFT
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire pap_pkg::pap_sample_t [NUM_PHASES-1:0] phase_samples,
  input wire logic [31:0] config_register,
  input wire logic [31:0] computation_mode_register,
  input wire logic [31:0] nominal_voltage_scale,
  input wire logic [NUM_PHASES-1:0][31:0] phase_power_gain,
  output logic [NUM_PHASES-1:0][23:0] inst_active_power,
  output logic [NUM_PHASES-1:0][23:0] fund_active_power,
  output logic power_valid
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PHASES < 1 || LPF_SHIFT < 1 || LPF_SHIFT > 20 || FUND_LPF_SHIFT < 1 || FUND_LPF_SHIFT > 20) begin : g_chk
    $error("pap_datapath: unsupported parameter value");
  end

  localparam int AW = pap_pkg::ACC_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Unpacked so that each selected element keeps its sign; a packed element would shift logically.
  logic signed [AW-1:0] stage1 [NUM_PHASES];
  logic signed [AW-1:0] next_stage1 [NUM_PHASES];
  logic signed [AW-1:0] stage2 [NUM_PHASES];
  logic signed [AW-1:0] next_stage2 [NUM_PHASES];
  logic signed [AW-1:0] volt_fund [NUM_PHASES];
  logic signed [AW-1:0] next_volt_fund [NUM_PHASES];
  logic signed [AW-1:0] curr_fund [NUM_PHASES];
  logic signed [AW-1:0] next_curr_fund [NUM_PHASES];
  logic signed [AW-1:0] fund_acc [NUM_PHASES];
  logic signed [AW-1:0] next_fund_acc [NUM_PHASES];
  logic [NUM_PHASES-1:0][23:0] next_inst_active_power;
  logic [NUM_PHASES-1:0][23:0] next_fund_active_power;
  logic next_power_valid;

  // Sign-extends the low 24 bits of a 32-bit transfer word to 28 bits; the top eight bits are ignored.
  function automatic logic signed [27:0] word_to_28(input logic [31:0] w);
    word_to_28 = {{4{w[23]}}, w[23:0]};
  endfunction

  // Scales by one plus gain over two to the 23rd, then applies the output divide by sixteen.
  function automatic logic [23:0] apply_gain(input logic signed [AW-1:0] p, input logic signed [27:0] g);
    logic signed [AW+27:0] prod;
    logic signed [AW+27:0] sum;
    prod = '0;
    sum = '0;
    prod = (AW+28)'(p) * (AW+28)'(g);
    sum = (AW+28)'(p) + (prod >>> pap_pkg::GAIN_SHIFT);
    apply_gain = 24'(sum >>> pap_pkg::OUT_SHIFT);
  endfunction

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [47:0] prod;
    logic signed [AW-1:0] inst;
    logic signed [AW-1:0] total;
    logic signed [63:0] fprod;
    logic signed [AW-1:0] finst;
    logic signed [27:0] vscale;
    logic signed [27:0] gain;
    int pre_shift;
    prod = '0;
    inst = '0;
    total = '0;
    fprod = '0;
    finst = '0;
    gain = '0;
    vscale = word_to_28(nominal_voltage_scale);
    // Line frequency picks the fundamental pre-filter corner.
    pre_shift = computation_mode_register[pap_pkg::COMPUTATION_MODE_REGISTER_LINE_FREQ_BIT] ?
      pap_pkg::FUND_PRE_SHIFT_60HZ : pap_pkg::FUND_PRE_SHIFT_50HZ;
    next_stage1 = stage1;
    next_stage2 = stage2;
    next_volt_fund = volt_fund;
    next_curr_fund = curr_fund;
    next_fund_acc = fund_acc;
    next_inst_active_power = inst_active_power;
    next_fund_active_power = fund_active_power;
    next_power_valid = 1'b0;
    if (sample_valid) begin
      next_power_valid = 1'b1;
      for (int ph = 0; ph < NUM_PHASES; ph++) begin
        gain = word_to_28(phase_power_gain[ph]);
        // Total path: product then one or two one-pole stages.
        prod = 48'(phase_samples[ph].volt) * 48'(phase_samples[ph].curr);
        inst = AW'(prod >>> pap_pkg::PROD_SHIFT);
        next_stage1[ph] = stage1[ph] + ((inst - stage1[ph]) >>> LPF_SHIFT);
        next_stage2[ph] = stage2[ph] + ((stage1[ph] - stage2[ph]) >>> LPF_SHIFT);
        total = config_register[pap_pkg::CFG_FILTER_STRENGTH_BIT] ? stage2[ph] : stage1[ph];
        next_inst_active_power[ph] = apply_gain(total, gain);
        // Fundamental path: pre-filtered voltage and current strip harmonics before the product.
        next_volt_fund[ph] = volt_fund[ph] + ((AW'(phase_samples[ph].volt) - volt_fund[ph]) >>> pre_shift);
        next_curr_fund[ph] = curr_fund[ph] + ((AW'(phase_samples[ph].curr) - curr_fund[ph]) >>> pre_shift);
        fprod = 64'(volt_fund[ph]) * 64'(curr_fund[ph]);
        // Nominal-voltage scale of 4194304 (two to the 22nd) is treated as unity; this trades exact scaling for a shift.
        fprod = (fprod >>> pap_pkg::PROD_SHIFT) * 64'(vscale);
        finst = AW'(fprod >>> pap_pkg::VSCALE_SHIFT);
        next_fund_acc[ph] = fund_acc[ph] + ((finst - fund_acc[ph]) >>> FUND_LPF_SHIFT);
        next_fund_active_power[ph] = apply_gain(fund_acc[ph], gain);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '{default: '0};
      stage2 <= '{default: '0};
      volt_fund <= '{default: '0};
      curr_fund <= '{default: '0};
      fund_acc <= '{default: '0};
      inst_active_power <= '0;
      fund_active_power <= '0;
      power_valid <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      volt_fund <= next_volt_fund;
      curr_fund <= next_curr_fund;
      fund_acc <= next_fund_acc;
      inst_active_power <= next_inst_active_power;
      fund_active_power <= next_fund_active_power;
      power_valid <= next_power_valid;
    end
  end

endmodule // pap_datapath

`default_nettype wire

// ### pap_pkg.sv
// Package with constants and types for the per-phase active power datapath.
package pap_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PHASES = 3;
  localparam int SAMPLE_W = 24;
  localparam int POWER_W = 24;
  localparam int WORD_W = 32;
  localparam int ACC_W = 32;

  // ----------------------------------------------------------------
  // Timing, in its own units, and derived sample counts
  // ----------------------------------------------------------------
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int STD_SETTLE_MS = 650;
  localparam int STRONG_SETTLE_MS = 1300;
  localparam int FUND_SETTLE_MS = 875;
  localparam int FUND_SETTLE_63_MS = 375;
  // One-pole settles to the stated accuracy in about five time constants.
  localparam int SETTLE_TAUS = 5;
  localparam int STD_SETTLE_SAMPLES = STD_SETTLE_MS * SAMPLE_RATE_HZ / 1000;
  localparam int FUND_SETTLE_SAMPLES = FUND_SETTLE_MS * SAMPLE_RATE_HZ / 1000;
  localparam int LPF_SHIFT = $clog2(STD_SETTLE_SAMPLES / SETTLE_TAUS) - 1;
  localparam int FUND_LPF_SHIFT = $clog2(FUND_SETTLE_SAMPLES / SETTLE_TAUS) - 1;

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  // Full-scale in-phase product mean over this shift gives the full-scale power constant.
  localparam int PROD_SHIFT = 19;
  localparam int FULL_SCALE_POWER = 26991271;
  localparam int OUT_SHIFT = 4;
  localparam int GAIN_SHIFT = 23;
  localparam int VSCALE_SHIFT = 22;
  // Fundamental pre-filter corner per line frequency.
  localparam int FUND_PRE_SHIFT_50HZ = 5;
  localparam int FUND_PRE_SHIFT_60HZ = 4;

  // ----------------------------------------------------------------
  // Register field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_FILTER_STRENGTH_BIT = 5;
  localparam int COMPUTATION_MODE_REGISTER_LINE_FREQ_BIT = 14;
  localparam logic [31:0] GAIN_RESET = 32'h0000_0000;
  localparam logic [31:0] POWER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] volt;
    logic signed [SAMPLE_W-1:0] curr;
  } pap_sample_t;

  typedef struct packed {
    logic [POWER_W-1:0] total;
    logic [POWER_W-1:0] fund;
  } pap_power_t;

endpackage

// ### pap_host_model.sv
// Host-side model that packs register words for the power datapath.
`timescale 1ns/1ps
`default_nettype none
module pap_host_model (
  input wire logic [23:0] vscale_raw,
  input wire logic [2:0][23:0] gain_raw,
  output logic [31:0] vscale_word,
  output logic [2:0][31:0] gain_word
);
  // The top nibble stays zero so a stray write cannot reach unused DSP bits.
  always_comb begin
    vscale_word = {4'h0, {4{vscale_raw[23]}}, vscale_raw};
    for (int i = 0; i < 3; i++) begin
      gain_word[i] = {4'h0, {4{gain_raw[i][23]}}, gain_raw[i]};
    end
  end
endmodule // pap_host_model
`default_nettype wire

// ### pap_datapath_monitor.sv
// Concurrent checks on the power datapath ports.
`timescale 1ns/1ps
`default_nettype none
module pap_datapath_monitor #(parameter int NUM_PHASES = pap_pkg::NUM_PHASES) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [NUM_PHASES-1:0][31:0] phase_power_gain,
  input wire logic [NUM_PHASES-1:0][23:0] inst_active_power,
  input wire logic [NUM_PHASES-1:0][23:0] fund_active_power,
  input wire logic power_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_valid_after_sample: assert property (sample_valid |=> power_valid)
    else $error("power_valid missing");
  a_no_spurious_valid: assert property (!sample_valid |=> !power_valid)
    else $error("power_valid without sample");
  a_total_holds_idle: assert property (!sample_valid |=> $stable(inst_active_power))
    else $error("total power moved while idle");
  a_fund_holds_idle: assert property (!sample_valid |=> $stable(fund_active_power))
    else $error("fundamental power moved while idle");
  a_update_with_valid: assert property (!power_valid |-> $stable(inst_active_power))
    else $error("power changed without power_valid");
  a_reset_clears_out: assert property ($rose(arst_n) |-> inst_active_power == '0 && !power_valid)
    else $error("outputs not cleared after reset");
  a_total_gain_null: assert property (sample_valid && phase_power_gain[2][23:0] == 24'h800000
    |=> inst_active_power[2] == 24'h000000)
    else $error("gain of minus one left total power");
  a_fund_gain_null: assert property (sample_valid && phase_power_gain[2][23:0] == 24'h800000
    |=> fund_active_power[2] == 24'h000000)
    else $error("gain of minus one left fundamental power");
  c_sample_answer: cover property (sample_valid ##1 power_valid);
  c_gain_half: cover property (sample_valid && phase_power_gain[0][23:0] == 24'hC00000);
  c_gain_up: cover property (sample_valid && phase_power_gain[0][23:0] == 24'h400000);
endmodule // pap_datapath_monitor
bind pap_datapath pap_datapath_monitor #(.NUM_PHASES(NUM_PHASES)) u_monitor (.core_clk(core_clk),
  .arst_n(arst_n), .sample_valid(sample_valid), .phase_power_gain(phase_power_gain),
  .inst_active_power(inst_active_power), .fund_active_power(fund_active_power), .power_valid(power_valid));
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the per-phase active power datapath.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sample_valid = 1'b0;
  pap_pkg::pap_sample_t [2:0] phase_samples = '0;
  logic [31:0] cfg = '0;
  logic [31:0] cmode = '0;
  logic [23:0] vraw = 24'h400000;
  logic [2:0][23:0] graw = '0;
  logic [31:0] vword;
  logic [2:0][31:0] gword;
  logic [2:0][23:0] inst_p;
  logic [2:0][23:0] fund_p;
  logic power_valid;
  int errors = 0;
  int num_checks = 0;
  logic [23:0] gtab [4] = '{24'h000000, 24'hC00000, 24'h400000, 24'h7FFFFF};
  always #12.5 core_clk = ~core_clk;
  pap_host_model i_host (.vscale_raw(vraw), .gain_raw(graw), .vscale_word(vword), .gain_word(gword));
  // Short filter shifts keep each settle to a few hundred samples.
  pap_datapath #(.LPF_SHIFT(2), .FUND_LPF_SHIFT(3)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .sample_valid(sample_valid), .phase_samples(phase_samples), .config_register(cfg),
    .computation_mode_register(cmode), .nominal_voltage_scale(vword), .phase_power_gain(gword),
    .inst_active_power(inst_p), .fund_active_power(fund_p), .power_valid(power_valid));
  // ------
  // Helpers
  // ------
  function automatic longint expect_pwr(logic signed [23:0] v, logic signed [23:0] c, logic [23:0] g);
    longint p;
    p = (longint'(v) * longint'(c)) >>> 19;
    p = p + ((p * longint'(signed'(g))) >>> 23);
    return p >>> 4;
  endfunction
  task automatic compare_power(logic [23:0] got, longint exp, longint tol);
    longint d;
    num_checks++;
    d = longint'(signed'(got)) - exp;
    if ((^got === 1'bx) || d > tol || d < -tol) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp[23:0]);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic run_samples(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) sample_valid <= 1'b1;
      @(posedge core_clk) sample_valid <= 1'b0;
    end
    @(negedge core_clk);
    compare_power({23'h0, power_valid}, 1, 0);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    close_out();
  end
  initial begin
    logic signed [23:0] v [3];
    logic signed [23:0] c [3];
    longint e;
    void'($urandom(86));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      for (int p = 0; p < 3; p++) begin
        v[p] = 24'($urandom_range(0, 24'h7FFFFF) - 24'h400000);
        c[p] = 24'($urandom_range(0, 24'h7FFFFF) - 24'h400000);
        phase_samples[p] <= {v[p], c[p]};
      end
      cfg[5] <= k[0];
      cmode[14] <= k[1];
      graw <= {24'h800000, 24'($urandom_range(0, 24'hFFFFFF)), gtab[k[1:0]]};
      run_samples(600);
      for (int p = 0; p < 3; p++) begin
        e = expect_pwr(v[p], c[p], graw[p]);
        compare_power(inst_p[p], e, 3);
        compare_power(fund_p[p], e, 64 + ((e < 0 ? -e : e) >>> 6));
      end
    end
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(negedge core_clk);
    compare_power(inst_p[0], 0, 0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    run_samples(4);
    close_out();
  end
endmodule // tb
`default_nettype wire
